// [hdl/ior_output_reg.sv]
// output register stage of a programmable io cell: sdr flop/latch, generic and memory ddr
`timescale 1ns/1ps
module ior_output_reg
  import ior_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic local_set_reset_in,
  input wire logic core_out_bit_first_in,
  input wire logic core_out_bit_second_in,
  input wire logic write_strobe_quarter_shift_in,
  input wire logic [IOR_AW-1:0] reg_addr_in,
  input wire logic [IOR_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [IOR_DW-1:0] reg_rdata_out,
  output logic pin_out
);
  logic [IOR_CW-1:0] ctrl_ff;
  logic [IOR_CW-1:0] nxt_ctrl;
  logic [IOR_DW-1:0] rdata_ff;
  logic [IOR_DW-1:0] nxt_rdata;
  logic rise_capture_reg_ff;
  logic rise_second_ff;
  logic fall_retime_reg_ff;
  logic sdr_store_ff;
  logic sdr_latch;

  wire ior_mode_t mode_cfg;
  wire ior_mode_t eff_mode;
  wire logic latch_sel;
  wire logic init_val;
  wire logic right_edge;
  wire logic is_ddr;
  wire logic sdr_q;
  wire logic ctrl_hit;
  wire logic stat_hit;
  wire logic [IOR_DW-1:0] ctrl_word;
  wire logic [IOR_DW-1:0] stat_word;

  // ---------------------------------------------------------------- control
  assign mode_cfg = ior_mode_t'(ctrl_ff[IOR_MODE_MSB:IOR_MODE_LSB]);
  assign latch_sel = ctrl_ff[IOR_LATCH_BIT];
  assign init_val = ctrl_ff[IOR_INIT_BIT];
  assign right_edge = ctrl_ff[IOR_RIGHT_BIT];

  // memory mode exists only on right-edge cells; elsewhere it falls back to generic,
  // and the spare code is read as single-rate so the pin never floats to a guess
  assign eff_mode = (mode_cfg == IOR_MODE_RSVD) ? IOR_MODE_SDR :
                    ((mode_cfg == IOR_MODE_DDR_MEM) && !right_edge) ? IOR_MODE_DDR_GEN :
                    mode_cfg;
  assign is_ddr = (eff_mode == IOR_MODE_DDR_GEN) || (eff_mode == IOR_MODE_DDR_MEM);

  assign ctrl_hit = (reg_addr_in == IOR_CTRL_OFS);
  assign stat_hit = (reg_addr_in == IOR_STAT_OFS);

  assign nxt_ctrl = (reg_wr_in && ctrl_hit) ? reg_wdata_in[IOR_CW-1:0] : ctrl_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_ff <= IOR_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ---------------------------------------------------------------- read port
  assign ctrl_word = {{(IOR_DW-IOR_CW){1'b0}}, ctrl_ff};
  assign stat_word = {{(IOR_DW-7){1'b0}}, eff_mode, pin_out, sdr_q,
                      fall_retime_reg_ff, rise_second_ff, rise_capture_reg_ff};
  // unmapped addresses and idle cycles read as zero
  assign nxt_rdata = !reg_rd_in ? IOR_RDATA_RST :
                     ctrl_hit ? ctrl_word :
                     stat_hit ? stat_word : IOR_RDATA_RST;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_ff <= IOR_RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out = rdata_ff;

  // ---------------------------------------------------------------- rising-edge capture
  // local set/reset loads the configured init value; the async reset only
  // gives the constant before configuration is known
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_capture_reg_ff <= IOR_REG_RST;
      rise_second_ff <= IOR_REG_RST;
      sdr_store_ff <= IOR_REG_RST;
    end else if (local_set_reset_in) begin
      rise_capture_reg_ff <= init_val;
      rise_second_ff <= init_val;
      sdr_store_ff <= init_val;
    end else begin
      rise_capture_reg_ff <= core_out_bit_first_in;
      rise_second_ff <= core_out_bit_second_in;
      sdr_store_ff <= core_out_bit_first_in;
    end
  end

  // ---------------------------------------------------------------- falling-edge retime
  // the second bit gets half a period to settle before it reaches the pin
  always_ff @(negedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fall_retime_reg_ff <= IOR_REG_RST;
    end else if (local_set_reset_in) begin
      fall_retime_reg_ff <= init_val;
    end else begin
      fall_retime_reg_ff <= rise_second_ff;
    end
  end

  // ---------------------------------------------------------------- sdr latch
  // transparent while the clock is high; limitation: data must be steady
  // around the falling edge, as for any latch
  always_latch begin
    if (!nrst_in) begin
      sdr_latch = IOR_REG_RST;
    end else if (local_set_reset_in) begin
      sdr_latch = init_val;
    end else if (clk_in) begin
      sdr_latch = core_out_bit_first_in;
    end
  end

  assign sdr_q = latch_sel ? sdr_latch : sdr_store_ff;

  // ---------------------------------------------------------------- pin mux
  // the pin cannot come from one flop: it changes every half period
  ior_out_mux u_mux (
    .mode_in(eff_mode),
    .clk_in(clk_in),
    .write_strobe_quarter_shift_in(write_strobe_quarter_shift_in),
    .sdr_q_in(sdr_q),
    .rise_q_in(rise_capture_reg_ff),
    .fall_q_in(fall_retime_reg_ff),
    .pin_out(pin_out)
  );

  // ---------------------------------------------------------------- checks
  a_rise_first_capture: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (is_ddr && !local_set_reset_in) |=> (rise_capture_reg_ff == $past(core_out_bit_first_in))
  ) else $error("first bit not captured on rising edge");

  a_rise_second_capture: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !local_set_reset_in |=> (rise_second_ff == $past(core_out_bit_second_in))
  ) else $error("second bit not captured on rising edge");

  a_fall_retime_copy: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (!local_set_reset_in && $past(!local_set_reset_in)) |-> (fall_retime_reg_ff == rise_second_ff)
  ) else $error("falling register does not hold the captured second bit");

  a_sdr_flop_path: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (eff_mode == IOR_MODE_SDR && !latch_sel && !local_set_reset_in) ##1 (eff_mode == IOR_MODE_SDR && !latch_sel)
    |-> (pin_out == $past(core_out_bit_first_in))
  ) else $error("single-rate pin does not follow the stored first bit");

  a_sdr_latch_path: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (eff_mode == IOR_MODE_SDR && latch_sel) |-> (pin_out == sdr_latch)
  ) else $error("latch selected but pin not driven from the latch");

  a_gen_low_half: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (eff_mode == IOR_MODE_DDR_GEN) |-> (pin_out == fall_retime_reg_ff)
  ) else $error("generic mode low half does not show the falling register");

  a_gen_high_half: assert property (
    @(negedge clk_in) disable iff (!nrst_in)
    (eff_mode == IOR_MODE_DDR_GEN) |-> (pin_out == rise_capture_reg_ff)
  ) else $error("generic mode high half does not show the rising register");

  a_mem_strobe_mux: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (eff_mode == IOR_MODE_DDR_MEM)
    |-> (pin_out == (write_strobe_quarter_shift_in ? rise_capture_reg_ff : fall_retime_reg_ff))
  ) else $error("memory mode mux not steered by the write strobe");

  a_mem_right_only: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (mode_cfg == IOR_MODE_DDR_MEM) |-> (eff_mode == (right_edge ? IOR_MODE_DDR_MEM : IOR_MODE_DDR_GEN))
  ) else $error("memory mode outside a right-edge cell");

  a_lsr_init_load: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    local_set_reset_in ##1 local_set_reset_in
    |-> (rise_capture_reg_ff == $past(init_val)) && (sdr_store_ff == $past(init_val))
        && (fall_retime_reg_ff == $past(init_val))
  ) else $error("registers not at configured init value under local set/reset");

  a_ctrl_write_steer: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (reg_wr_in && ctrl_hit) |=> (ctrl_ff == $past(reg_wdata_in[IOR_CW-1:0]))
  ) else $error("control write not stored");

  a_read_one_cycle: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (reg_rd_in && ctrl_hit) |=> (reg_rdata_out == {{(IOR_DW-IOR_CW){1'b0}}, $past(ctrl_ff)})
  ) else $error("control read data wrong in the following cycle");
endmodule : ior_output_reg

// [include/ior_pkg.sv]
// constants and types shared by the output register stage
package ior_pkg;
  localparam int IOR_AW = 8;
  localparam int IOR_DW = 32;
  localparam int IOR_CW = 5;

  // register offsets (byte addresses)
  localparam logic [IOR_AW-1:0] IOR_CTRL_OFS = 8'h00;
  localparam logic [IOR_AW-1:0] IOR_STAT_OFS = 8'h04;

  // control field positions
  localparam int IOR_MODE_LSB = 0;
  localparam int IOR_MODE_MSB = 1;
  localparam int IOR_LATCH_BIT = 2;
  localparam int IOR_INIT_BIT = 3;
  localparam int IOR_RIGHT_BIT = 4;

  // status field positions
  localparam int IOR_ST_RISE0_BIT = 0;
  localparam int IOR_ST_RISE1_BIT = 1;
  localparam int IOR_ST_FALL_BIT = 2;
  localparam int IOR_ST_SDR_BIT = 3;
  localparam int IOR_ST_PIN_BIT = 4;
  localparam int IOR_ST_MODE_LSB = 5;
  localparam int IOR_ST_MODE_MSB = 6;

  // reset values
  localparam logic [IOR_CW-1:0] IOR_CTRL_RST = 5'h00;
  localparam logic IOR_REG_RST = 1'h0;
  localparam logic [IOR_DW-1:0] IOR_RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    IOR_MODE_SDR,
    IOR_MODE_DDR_GEN,
    IOR_MODE_DDR_MEM,
    IOR_MODE_RSVD
  } ior_mode_t;
endpackage : ior_pkg

// [hdl/ior_out_mux.sv]
// output multiplexer in front of the pin
`timescale 1ns/1ps
module ior_out_mux
  import ior_pkg::*;
(
  input wire ior_mode_t mode_in,
  input wire logic clk_in,
  input wire logic write_strobe_quarter_shift_in,
  input wire logic sdr_q_in,
  input wire logic rise_q_in,
  input wire logic fall_q_in,
  output logic pin_out
);
  wire logic ddr_sel;
  wire logic ddr_bit;

  // the select is the clock or the shifted strobe itself, never a sampled copy:
  // sampling would cost the half-period that carries the second bit
  assign ddr_sel = (mode_in == IOR_MODE_DDR_MEM) ? write_strobe_quarter_shift_in : clk_in;
  assign ddr_bit = ddr_sel ? rise_q_in : fall_q_in;
  assign pin_out = (mode_in == IOR_MODE_SDR) ? sdr_q_in : ddr_bit;
endmodule : ior_out_mux

// [sim/ior_rx_model.sv]
// receiver on the pin: samples each half period and sources the memory write strobe
`timescale 1ns/1ps
module ior_rx_model (
  input wire logic clk_in,
  input wire logic pin_in,
  input wire logic strobe_en_in,
  output logic strobe_out,
  output logic early_bit_out,
  output logic late_bit_out
);
  initial begin
    strobe_out = 1'h0;
    early_bit_out = 1'h0;
    late_bit_out = 1'h0;
  end
  // strobe lags the clock by a quarter period and stands still while disabled
  always @(posedge clk_in) strobe_out <= #2 strobe_en_in;
  always @(negedge clk_in) strobe_out <= #2 1'h0;
  // one ns into each half, so the fall register has already moved
  always begin
    @(posedge clk_in);
    #1;
    early_bit_out = pin_in;
  end
  always begin
    @(negedge clk_in);
    #1;
    late_bit_out = pin_in;
  end
endmodule : ior_rx_model

// [sim/testbench.sv]
// self-checking bench for the output register stage
`timescale 1ns/1ps
module testbench;
  import ior_pkg::*;
  logic clk_in, nrst_in, local_set_reset, d_first, d_second, wr, rd, strobe_en, strobe, early, late, pin;
  logic [IOR_AW-1:0] addr;
  logic [IOR_DW-1:0] wdata, rdata, rv;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [9:0] PA = 10'h2d3;
  localparam logic [9:0] PB = 10'h1b6;
  ior_output_reg ior_output_reg_i (.clk_in(clk_in), .nrst_in(nrst_in), .local_set_reset_in(local_set_reset),
    .core_out_bit_first_in(d_first), .core_out_bit_second_in(d_second),
    .write_strobe_quarter_shift_in(strobe), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pin_out(pin));
  ior_rx_model ior_rx_model_i (.clk_in(clk_in), .pin_in(pin), .strobe_en_in(strobe_en),
    .strobe_out(strobe), .early_bit_out(early), .late_bit_out(late));
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [IOR_DW-1:0] got, input logic [IOR_DW-1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : chk_word
  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic reg_write(input logic [IOR_AW-1:0] a, input logic [IOR_DW-1:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
  endtask : reg_write
  task automatic reg_read(input logic [IOR_AW-1:0] a, output logic [IOR_DW-1:0] d);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask : reg_read
  // kind: 0 flop, 1 latch, 2 generic double rate, 3 memory double rate
  task automatic stream(input int kind);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      d_first <= PA[i];
      d_second <= PB[i];
      @(negedge clk_in);
      #2;
      if (i >= 2) begin
        chk_bit(early, kind == 1 ? PA[i] : (kind == 3 ? PB[i-2] : PA[i-1]), "high half");
        chk_bit(late, kind == 1 ? PA[i] : (kind == 2 ? PB[i-1] : PA[i-1]), "low half");
      end
    end
  endtask : stream
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    {nrst_in, local_set_reset, d_first, d_second, wr, rd, strobe_en} = 7'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (12) @(posedge clk_in);
    chk_bit(pin, 1'h0, "pin in reset");
    nrst_in <= 1'h1;
    reg_read(IOR_CTRL_OFS, rv);
    chk_word(rv, 32'h0000_0000, "ctrl reset");
    @(posedge clk_in);
    #1;
    chk_word(rdata, 32'h0000_0000, "read data lingers");
    reg_read(IOR_STAT_OFS, rv);
    chk_word(rv, 32'h0000_0000, "status reset");
    reg_write(IOR_CTRL_OFS, 32'hffff_ffff);
    reg_write(8'h08, 32'h0000_0000);
    reg_read(IOR_CTRL_OFS, rv);
    chk_word(rv, 32'h0000_001f, "ctrl readback");
    reg_read(8'h08, rv);
    chk_word(rv, 32'h0000_0000, "unmapped read");
    reg_write(IOR_CTRL_OFS, 32'h0000_0000);
    stream(0);
    reg_write(IOR_CTRL_OFS, 32'h0000_0004);
    stream(1);
    reg_write(IOR_CTRL_OFS, 32'h0000_0001);
    stream(2);
    reg_write(IOR_CTRL_OFS, 32'h0000_0012);
    strobe_en <= 1'h1;
    stream(3);
    reg_read(IOR_STAT_OFS, rv);
    chk_word({30'h0, rv[6:5]}, 32'h0000_0002, "memory mode status");
    // memory mode on a non right-edge cell must ignore the running strobe
    reg_write(IOR_CTRL_OFS, 32'h0000_0002);
    stream(2);
    strobe_en <= 1'h0;
    reg_write(IOR_CTRL_OFS, 32'h0000_0003);
    stream(0);
    reg_write(IOR_CTRL_OFS, 32'h0000_0009);
    @(posedge clk_in);
    local_set_reset <= 1'h1;
    d_first <= 1'h0;
    d_second <= 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
    chk_bit(pin, 1'h1, "set high half");
    @(negedge clk_in);
    #1;
    chk_bit(pin, 1'h1, "set low half");
    reg_read(IOR_STAT_OFS, rv);
    chk_word({29'h0, rv[2:0]}, 32'h0000_0007, "set registers");
    @(posedge clk_in);
    local_set_reset <= 1'h0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    #1;
    chk_bit(pin, 1'h0, "data after set");
    // latch with init cleared: local set/reset must override the open latch
    reg_write(IOR_CTRL_OFS, 32'h0000_0004);
    @(posedge clk_in);
    local_set_reset <= 1'h1;
    d_first <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    chk_bit(pin, 1'h0, "latch held at reset value");
    @(posedge clk_in);
    local_set_reset <= 1'h0;
    #1;
    chk_bit(pin, 1'h1, "latch open after reset");
    finish_test();
  end
endmodule : testbench
